// ---- verilog/eeprom_pkg.sv ----
package eeprom_pkg;

   // Register bus geometry.
   typedef logic [31:0] axi_data_type;
   typedef logic [7:0]  axi_addr_type;

   // Register byte offsets.
   localparam axi_addr_type CTRL_OFFSET   = 8'h00;
   localparam axi_addr_type STATUS_OFFSET = 8'h04;
   localparam axi_addr_type WCOUNT_OFFSET = 8'h08;

   // Field positions.
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_WP_BIT   = 1;
   localparam int STATUS_FIFO_BIT = 2;
   localparam int STATUS_ADDR_LSB = 8;

   // Reset values.
   localparam logic CTRL_ENABLE_RESET = 1'b1;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Device type nibble that precedes the strapped select bits.
   localparam logic [3:0] DEV_TYPE_CODE = 4'ha;

   // Array geometry.
   localparam int MEM_BYTES  = 256;
   localparam int PAGE_BYTES = 8;
   localparam int FIFO_DEPTH = 4;

   // Self-timed write cycle, a longest time, so the count rounds down.
   localparam int CLK_FREQ_KHZ  = 25000;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_FREQ_KHZ / 1000;

   // Serial link states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEV   = 3'b001,
      ST_WORD  = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_ACK   = 3'b101,
      ST_MACK  = 3'b110
   } link_state_type;

endpackage

// ---- verilog/fifo_if.sv ----
interface fifo_if #(
   parameter int WIDTH = 8
) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   // The producer drives valid and data, the consumer drives ready.
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/stream_fifo.sv ----
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   fifo_if.snk      push_if,
   fifo_if.src      pop_if
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Full and empty come straight from the fill count.
   assign push_if.ready = (cnt_q != DEPTH[PW:0]);
   assign pop_if.valid  = (cnt_q != '0);
   assign pop_if.data   = mem_q[rd_q];
   assign push          = push_if.valid && push_if.ready;
   assign pop           = pop_if.valid && pop_if.ready;

   // Storage has no reset; only the pointers define the content.
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wr_q] <= push_if.data;
      end
   end

   // Pointers wrap by overflow, so the depth must be a power of two.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ---- verilog/two_wire_eeprom_target_port.sv ----
// Function
// - Sample incoming bits on serial clock rise.
// - Change driven data only after clock fall.
// - Data line only pulled low or released.
// - Answer only when select bits match straps.
// - Select and protect inputs read low only while in reset; nothing pulls undriven inputs low.
// - Array of 128 or 256 bytes.
// - Page write up to eight bytes, partial allowed.
// - Self-timed write ends within five milliseconds.
// - Protect input guards whole array.
// - Protect high inhibits writes, low allows them.
// - Random and sequential reads supported.
module two_wire_eeprom_target_port
   import eeprom_pkg::*;
#(
   parameter int MEM_DEPTH      = eeprom_pkg::MEM_BYTES,
   parameter int WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES,
   parameter int FIFO_DEPTH_P   = eeprom_pkg::FIFO_DEPTH
) (
   input  wire logic                     ref_clk_in,
   input  wire logic                     srst_in,
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output wire logic                     sda_out,
   output wire logic                     sda_oe_out,
   input  wire logic                     addr_strap_bit0_in,
   input  wire logic                     addr_strap_bit1_in,
   input  wire logic                     addr_strap_bit2_in,
   input  wire logic                     wp_in,
   input  wire logic                     s_axi_awvalid_in,
   output wire logic                     s_axi_awready_out,
   input  wire eeprom_pkg::axi_addr_type s_axi_awaddr_in,
   input  wire logic                     s_axi_wvalid_in,
   output wire logic                     s_axi_wready_out,
   input  wire eeprom_pkg::axi_data_type s_axi_wdata_in,
   input  wire logic [3:0]               s_axi_wstrb_in,
   output wire logic                     s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   output wire logic [1:0]               s_axi_bresp_out,
   input  wire logic                     s_axi_arvalid_in,
   output wire logic                     s_axi_arready_out,
   input  wire eeprom_pkg::axi_addr_type s_axi_araddr_in,
   output wire logic                     s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in,
   output wire eeprom_pkg::axi_data_type s_axi_rdata_out,
   output wire logic [1:0]               s_axi_rresp_out
);
   import eeprom_pkg::*;

   localparam int AW = $clog2(MEM_DEPTH);
   localparam int PB = $clog2(PAGE_BYTES);

   logic [5:0]     sync1_q;
   logic [5:0]     sync2_q;
   logic           scl_p_q;
   logic           sda_p_q;
   logic           scl_s;
   logic           sda_s;
   logic [2:0]     strap_s;
   logic           wp_s;
   logic           scl_rise;
   logic           scl_fall;
   logic           start_det;
   logic           stop_det;
   link_state_type state_q;
   link_state_type next_q;
   logic [3:0]     bit_cnt_q;
   logic [7:0]     shift_q;
   logic [7:0]     out_q;
   logic           sda_oe_q;
   logic           mack_q;
   logic [AW-1:0]  addr_q;
   logic           ack_ok;
   link_state_type after_ack;
   logic           push_pend_q;
   logic [AW+7:0]  push_data_q;
   logic [7:0]     page_data_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_valid_q;
   logic [AW-PB-1:0] page_base_q;
   logic           commit_pend_q;
   logic           commit_go;
   logic           busy_q;
   logic [31:0]    wcnt_q;
   logic           write_done;
   logic [7:0]     mem_q [MEM_DEPTH];
   logic           ctrl_enable_q;
   logic [31:0]    wcount_q;
   logic           aw_got_q;
   logic           w_got_q;
   axi_addr_type   aw_addr_q;
   axi_data_type   w_data_q;
   logic [3:0]     w_strb_q;
   logic           bvalid_q;
   logic [1:0]     bresp_q;
   logic           rvalid_q;
   axi_data_type   rdata_q;
   logic [1:0]     rresp_q;

   fifo_if #(.WIDTH(AW + 8)) wr_if ();
   fifo_if #(.WIDTH(AW + 8)) rd_if ();

   // Pins cross into the clock domain through two flops each.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         // Clock and data start at their idle high level, so no false edge follows reset.
         sync1_q <= 6'h30;
         sync2_q <= 6'h30;
      end else begin
         sync1_q <= {scl_in, sda_in, addr_strap_bit2_in, addr_strap_bit1_in,
                     addr_strap_bit0_in, wp_in};
         sync2_q <= sync1_q;
      end
   end

   // A third stage gives the previous level for edge detection.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_s     = sync2_q[5];
   assign sda_s     = sync2_q[4];
   assign strap_s   = sync2_q[3:1];
   assign wp_s      = sync2_q[0];
   assign scl_rise  = scl_s && !scl_p_q;
   assign scl_fall  = !scl_s && scl_p_q;
   // Data moving while the clock stays high marks frame bounds.
   assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;

   // Acknowledge decision for the byte just received.
   always_comb begin
      ack_ok    = 1'b0;
      after_ack = ST_IDLE;
      case (state_q)
         ST_DEV: begin
            ack_ok    = (shift_q[7:4] == DEV_TYPE_CODE) && (shift_q[3:1] == strap_s)
                        && ctrl_enable_q && !busy_q;
            after_ack = shift_q[0] ? ST_RDATA : ST_WORD;
         end
         ST_WORD: begin
            ack_ok    = 1'b1;
            after_ack = ST_WDATA;
         end
         ST_WDATA: begin
            ack_ok    = !push_pend_q;  // A byte not yet buffered is refused.
            after_ack = ST_WDATA;
         end
         default: begin
            ack_ok    = 1'b0;
            after_ack = ST_IDLE;
         end
      endcase
   end

   // Serial link sequencer; frame edges override every state.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_q   <= ST_IDLE;
         next_q    <= ST_IDLE;
         bit_cnt_q <= '0;
         shift_q   <= '0;
         out_q     <= '0;
         sda_oe_q  <= 1'b0;
         mack_q    <= 1'b0;
         addr_q    <= '0;
      end else if (stop_det) begin
         state_q  <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         state_q   <= ST_DEV;
         bit_cnt_q <= '0;
         sda_oe_q  <= 1'b0;
      end else begin
         case (state_q)
            ST_DEV, ST_WORD, ST_WDATA: begin
               if (scl_rise && bit_cnt_q < 4'd8) begin
                  shift_q   <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'd1;
               end else if (scl_fall && bit_cnt_q == 4'd8) begin
                  state_q   <= ST_ACK;
                  sda_oe_q  <= ack_ok;
                  next_q    <= ack_ok ? after_ack : ST_IDLE;
                  bit_cnt_q <= '0;
                  if (state_q == ST_WORD) begin
                     addr_q <= shift_q[AW-1:0];
                  end else if (state_q == ST_WDATA && ack_ok) begin
                     addr_q[PB-1:0] <= addr_q[PB-1:0] + 1'b1;
                  end
               end
            end
            ST_ACK, ST_MACK: begin
               if (scl_rise) begin
                  mack_q <= !sda_s;
               end else if (scl_fall) begin
                  if ((state_q == ST_ACK && next_q == ST_RDATA) ||
                      (state_q == ST_MACK && mack_q)) begin
                     state_q   <= ST_RDATA;
                     sda_oe_q  <= !mem_q[addr_q][7];
                     out_q     <= {mem_q[addr_q][6:0], 1'b0};
                     addr_q    <= addr_q + 1'b1;
                     bit_cnt_q <= 4'd1;
                  end else begin
                     state_q  <= (state_q == ST_ACK) ? next_q : ST_IDLE;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall && bit_cnt_q < 4'd8) begin
                  sda_oe_q  <= !out_q[7];
                  out_q     <= {out_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 4'd1;
               end else if (scl_fall) begin
                  state_q  <= ST_MACK;
                  sda_oe_q <= 1'b0;
                  mack_q   <= 1'b0;
               end
            end
            default: begin
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // The line is only ever pulled low or released.
   assign sda_out    = 1'b0;
   assign sda_oe_out = sda_oe_q;

   // Each received data byte is offered to the buffer with its address.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         push_pend_q <= 1'b0;
         push_data_q <= '0;
      end else if (state_q == ST_WDATA && scl_rise && bit_cnt_q == 4'd7 && !push_pend_q
                   && !start_det && !stop_det) begin
         push_pend_q <= 1'b1;
         push_data_q <= {addr_q, shift_q[6:0], sda_s};
      end else if (wr_if.ready) begin
         push_pend_q <= 1'b0;
      end
   end

   assign wr_if.valid = push_pend_q;
   assign wr_if.data  = push_data_q;
   // Draining stalls during the write cycle so the page stays stable.
   assign rd_if.ready = !busy_q;

   stream_fifo #(
      .WIDTH (AW + 8),
      .DEPTH (FIFO_DEPTH_P)
   ) u_byte_fifo (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .push_if    (wr_if.snk),
      .pop_if     (rd_if.src)
   );

   // Page buffer collects drained bytes; unsent bytes keep old content.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         page_valid_q <= '0;
         page_base_q  <= '0;
      end else if (rd_if.valid && rd_if.ready) begin
         page_data_q[rd_if.data[PB+7:8]]  <= rd_if.data[7:0];
         page_valid_q[rd_if.data[PB+7:8]] <= 1'b1;
         page_base_q                      <= rd_if.data[AW+7:PB+8];
      end else if (write_done || (commit_go && wp_s)) begin
         page_valid_q <= '0;
      end
   end

   assign commit_go  = commit_pend_q && !rd_if.valid && !push_pend_q;
   assign write_done = busy_q && (wcnt_q == WRITE_CYCLES_P - 1);

   // Commit waits for the buffer to drain, then runs the timed write.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         commit_pend_q <= 1'b0;
         busy_q        <= 1'b0;
         wcnt_q        <= '0;
         wcount_q      <= '0;
      end else begin
         if (stop_det && state_q == ST_WDATA) begin
            commit_pend_q <= 1'b1;
         end else if (commit_go) begin
            commit_pend_q <= 1'b0;
            busy_q        <= (page_valid_q != '0) && !wp_s;
         end
         if (write_done) begin
            busy_q   <= 1'b0;
            wcnt_q   <= '0;
            wcount_q <= wcount_q + 32'd1;
         end else if (busy_q) begin
            wcnt_q <= wcnt_q + 32'd1;
         end
      end
   end

   // The array changes only at the end of a timed write.
   always_ff @(posedge ref_clk_in) begin
      if (write_done) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_valid_q[i]) begin
               mem_q[{page_base_q, i[PB-1:0]}] <= page_data_q[i];
            end
         end
      end
   end

   // Write channel: address and data are taken in either order.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         bvalid_q      <= 1'b0;
         bresp_q       <= RESP_OKAY;
         ctrl_enable_q <= CTRL_ENABLE_RESET;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         if (aw_got_q && w_got_q) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            if (aw_addr_q == CTRL_OFFSET) begin
               bresp_q <= RESP_OKAY;
               if (w_strb_q[0]) begin
                  ctrl_enable_q <= w_data_q[CTRL_ENABLE_BIT];
               end
            end else if (aw_addr_q == STATUS_OFFSET || aw_addr_q == WCOUNT_OFFSET) begin
               bresp_q <= RESP_OKAY;
            end else begin
               bresp_q <= RESP_SLVERR;
            end
         end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready_out = !aw_got_q && !bvalid_q;
   assign s_axi_wready_out  = !w_got_q && !bvalid_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
         if (s_axi_araddr_in == CTRL_OFFSET) begin
            rdata_q[CTRL_ENABLE_BIT] <= ctrl_enable_q;
         end else if (s_axi_araddr_in == STATUS_OFFSET) begin
            rdata_q[STATUS_BUSY_BIT]               <= busy_q;
            rdata_q[STATUS_WP_BIT]                 <= wp_s;
            rdata_q[STATUS_FIFO_BIT]               <= rd_if.valid;
            rdata_q[STATUS_ADDR_LSB +: AW]         <= addr_q;
         end else if (s_axi_araddr_in == WCOUNT_OFFSET) begin
            rdata_q <= wcount_q;
         end else begin
            rresp_q <= RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;

   // Checks on the serial side and the write cycle.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_byte_in_done;
      (state_q == ST_DEV || state_q == ST_WORD || state_q == ST_WDATA)
      && scl_fall && bit_cnt_q == 4'd8 && !start_det && !stop_det;
   endsequence

   sequence s_foreign_addr;
      state_q == ST_DEV && shift_q[3:1] != strap_s;
   endsequence

   AST_SAMPLE_ON_RISE: assert property (
      (!scl_rise && !start_det && !stop_det) |=> $stable(shift_q))
      else $error("Shift register moved without a clock rise.");
   AST_DRIVE_ON_FALL: assert property (
      $changed(sda_oe_q) |-> $past(scl_fall) || $past(stop_det) || $past(start_det))
      else $error("Data line drive changed off a clock fall.");
   AST_OPEN_DRAIN: assert property (
      sda_out == 1'b0)
      else $error("Data line driven high.");
   AST_FOREIGN_NO_ACK: assert property (
      (s_byte_in_done and s_foreign_addr) |=> !sda_oe_q && next_q == ST_IDLE)
      else $error("Acknowledged a foreign select address.");
   AST_ACK_NINTH: assert property (
      (s_byte_in_done and (ack_ok && !busy_q)) |=> sda_oe_q && state_q == ST_ACK)
      else $error("Accepted byte was not acknowledged.");
   AST_WP_INHIBIT: assert property (
      (commit_go && wp_s) |=> !busy_q && page_valid_q == '0)
      else $error("Write cycle started while protected.");
   AST_WRITE_BOUND: assert property (
      busy_q |-> wcnt_q < WRITE_CYCLES_P)
      else $error("Write cycle overran its bound.");
   AST_WRITE_END: assert property (
      $fell(busy_q) |-> $past(wcnt_q) == WRITE_CYCLES_P - 1)
      else $error("Write cycle ended at the wrong count.");
   AST_PAGE_ROLL: assert property (
      (s_byte_in_done and (state_q == ST_WDATA && ack_ok))
      |=> addr_q[AW-1:PB] == $past(addr_q[AW-1:PB]))
      else $error("Page write crossed a page boundary.");
   AST_SEQ_READ: assert property (
      (state_q == ST_MACK && scl_fall && mack_q && !start_det && !stop_det)
      |=> state_q == ST_RDATA && addr_q == $past(addr_q) + 1'b1)
      else $error("Sequential read did not advance.");
endmodule

// ---- sim/i2c_ctrl_model.sv ----
module i2c_ctrl_model (
   input  wire logic ref_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Clock idles high and the data line is released at time zero.
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // Data changes only while the clock is low; one bit is 8 clocks.
   task automatic wbit(input logic b);
      scl_out <= 1'b0;
      tk(1);
      sda_low_out <= !b;
      tk(3);
      scl_out <= 1'b1;
      tk(4);
   endtask
   // Sampled late in the high phase, after the device output settles; 8 clocks a bit.
   task automatic rbit(output logic b);
      scl_out <= 1'b0;
      sda_low_out <= 1'b0;
      tk(4);
      scl_out <= 1'b1;
      tk(3);
      b = sda_in;
      tk(1);
   endtask
   task automatic start();
      scl_out <= 1'b0;
      tk(2);
      sda_low_out <= 1'b0;
      tk(2);
      scl_out <= 1'b1;
      tk(4);
      sda_low_out <= 1'b1;
      tk(4);
   endtask
   task automatic stop();
      wbit(1'b0);
      sda_low_out <= 1'b0;
      tk(8);
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) wbit(v[i]);
      rbit(b);
      ack = !b;
   endtask
   // The controller acknowledges every byte but the last of a read.
   task automatic rbyte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) rbit(v[i]);
      wbit(last);
   endtask
endmodule

// ---- sim/two_wire_eeprom_target_port_tb.sv ----
module two_wire_eeprom_target_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import eeprom_pkg::*;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
   logic clk = 0, srst = 1, wp = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic [2:0] strap = 0;
   axi_addr_type awa = 0, ara = 0;
   axi_data_type wd = 0, rd;
   wire logic awr, wr, bv, arr, rv, oe, scl, mlow, sda;
   wire logic [1:0] br, rr;
   axi_data_type rdo;
   logic [1:0] rs;
   logic [7:0] exp_mem [256];
   int n_errors = 0, checked = 0;
   // The shared data line: pulled up unless either party pulls it low.
   assign sda = !(oe | mlow);
   initial forever #20 clk = !clk;
   two_wire_eeprom_target_port #(.WRITE_CYCLES_P(200)) i_dut (.ref_clk_in(clk),
      .srst_in(srst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(oe),
      .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]),
      .addr_strap_bit2_in(strap[2]), .wp_in(wp), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rdo),
      .s_axi_rresp_out(rr));
   i2c_ctrl_model i_ctrl (.ref_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(mlow));
   // Handshakes are judged at the rising edge; the answer is taken at that same edge,
   // so the caller sees it at once instead of one scheduling step late.
   task automatic axi_wr(input axi_addr_type a, input axi_data_type d);
      @(posedge clk);
      {awv, wv, bre, awa, wd} <= {3'h7, a, d};
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end while (!(bre && bv));
      bre <= 1'b0;
      rs = br;
   endtask
   task automatic axi_rd(input axi_addr_type a);
      @(posedge clk);
      {arv, rre, ara} <= {2'h3, a};
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!(rre && rv));
      rre <= 1'b0;
      rd = rdo;
      rs = rr;
   endtask
   task automatic sel(input logic [2:0] s, input logic rw, input logic e);
      logic ack;
      i_ctrl.start();
      i_ctrl.wbyte({DEV_TYPE_CODE, s, rw}, ack);
      `CHK(ack, e)
   endtask
   // Page writes wrap inside the 8-byte page.
   function automatic logic [7:0] pg(input logic [7:0] a, input int i);
      return {a[7:3], a[2:0] + 3'(i)};
   endfunction
   task automatic do_write(input logic [7:0] a, input int n, input logic w);
      logic ack;
      logic [7:0] d;
      int polls, cnt;
      axi_rd(WCOUNT_OFFSET);
      cnt = rd;
      wp <= w;
      sel(strap, 1'b0, 1'b1);
      i_ctrl.wbyte(a, ack);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         i_ctrl.wbyte(d, ack);
         `CHK(ack, 1'b1)
         if (!w) exp_mem[pg(a, i)] = d;
      end
      i_ctrl.stop();
      polls = 0;
      do begin
         axi_rd(STATUS_OFFSET);
         polls++;
      end while (rd[STATUS_BUSY_BIT] === 1'b1 && polls < 300);
      `CHK(polls < 300, 1'b1)
      `CHK(rd[STATUS_WP_BIT], w)
      `CHK(rd[STATUS_FIFO_BIT], 1'b0)
      `CHK(rd[STATUS_ADDR_LSB +: 8], pg(a, n))
      axi_rd(WCOUNT_OFFSET);
      `CHK(rd, axi_data_type'(cnt + !w))
   endtask
   task automatic do_read(input logic [7:0] a, input int n);
      logic ack;
      logic [7:0] d;
      sel(strap, 1'b0, 1'b1);
      i_ctrl.wbyte(a, ack);
      sel(strap, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_ctrl.rbyte(i == n - 1, d);
         `CHK(d, exp_mem[8'(a + i)])
      end
      i_ctrl.stop();
      $display("test done at %0t", $time);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_errors++;
      stop_test();
   end
   initial begin
      logic [7:0] base;
      void'($urandom(67));
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      strap <= 3'($urandom);
      axi_rd(CTRL_OFFSET);
      `CHK({rs, rd[CTRL_ENABLE_BIT]}, {RESP_OKAY, CTRL_ENABLE_RESET})
      axi_rd(8'h0c);
      `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
      axi_wr(8'h0c, 32'h1);
      `CHK(rs, RESP_SLVERR)
      axi_wr(CTRL_OFFSET, 32'h0);
      `CHK(rs, RESP_OKAY)
      sel(strap, 1'b0, 1'b0);
      i_ctrl.stop();
      axi_wr(CTRL_OFFSET, 32'h1);
      sel(strap ^ 3'h1, 1'b0, 1'b0);
      i_ctrl.stop();
      for (int k = 0; k < 3; k++) begin
         base = 8'($urandom) & 8'hf8;
         do_write(base, 8, 1'b0);
         do_read(base, 8);
      end
      do_write(base + 8'h05, 5, 1'b0);
      do_read(base, 8);
      do_write(base, 3, 1'b1);
      do_read(base, 8);
      stop_test();
   end
endmodule
